// File: design/tppm_pkg.sv
// constants, types and field layout of the three-pin port multiplexer
// assumes one 250 MHz clock and AHB-Lite register access
//
// Behaviour
// - highest-priority selected function wins per pin
// - analog and timer functions claimed by peripheral enables, serial and pwm by register bits
// - level three: rx, tx, pwm on pins
// - pull-up bits 6-4 enable pins 2-0
// - direction bits 2-0: one means output
// - output pins never have pull-up active
// - data read: latch if output, else pin
// - pwm select bit 3 picks channel
// - pwm enable bit 2 routes pwm
// - mode 00: sci to lin, pins gpio
// - mode 01: sci on pins 0, 1
// - mode 10: lin phy on pins 0, 1
// - mode 11: internal link, pins mirror signals
// - timer channels 0-2 routed to pins 0-2
// - channel 3 captures internal rx, no output
package tppm_pkg;
    // =========================================================
    // sizes
    localparam int           NUM_PINS        = 3;
    localparam int           NUM_TIMER_CH    = 4;
    localparam int           REG_ADDR_W      = 4;
    // =========================================================
    // register byte offsets
    localparam logic [3:0]   ADDR_CFG_ONE    = 4'h0;
    localparam logic [3:0]   ADDR_CFG_TWO    = 4'h4;
    localparam logic [3:0]   ADDR_DATA       = 4'h8;
    localparam logic [3:0]   ADDR_UNMAPPED   = 4'hF;
    // =========================================================
    // field positions
    localparam int           PUE_LSB         = 4;
    localparam int           DIR_LSB         = 0;
    localparam int           PWM_CHANNEL_SELECT_BIT       = 3;
    localparam int           PWM_ROUTE_ENABLE_BIT       = 2;
    localparam int           SERIAL_MODE_LSB      = 0;
    localparam int           DATA_LSB        = 0;
    // =========================================================
    // reset values
    localparam logic [7:0]   CFG_ONE_RESET   = 8'h00;
    localparam logic [7:0]   CFG_TWO_RESET   = 8'h00;
    localparam logic [7:0]   DATA_RESET      = 8'h00;
    localparam logic [7:0]   CFG_ONE_MASK    = 8'h77;
    localparam logic [7:0]   CFG_TWO_MASK    = 8'h0F;
    localparam logic [7:0]   DATA_MASK       = 8'h07;
    // =========================================================
    // ahb encodings
    localparam logic [1:0]   HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]   HSIZE_WORD      = 3'h2;
    localparam logic         IDLE_LINE       = 1'b1;
    // =========================================================
    // types
    typedef enum logic [1:0] {
        SER_INTERNAL,
        SER_EXT_SCI,
        SER_EXT_LIN,
        SER_OBSERVE
    } tppm_sermode_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] analog_en;
        logic [NUM_PINS-1:0] timer_en;
        logic [NUM_PINS-1:0] timer_oc;
        logic [NUM_PINS-1:0] timer_out;
        logic [1:0]          pwm_out;
        logic                sci_txd;
        logic                lin_rxd;
    } tppm_periph_in_type;

    typedef struct packed {
        logic [NUM_TIMER_CH-1:0] timer_in;
        logic                    sci_rxd;
        logic                    lin_txd;
    } tppm_periph_out_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] pu;
    } tppm_pad_out_type;
endpackage : tppm_pkg

// File: design/tppm_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous inputs; output changes when stages two and three agree
`timescale 1ns/10ps
module tppm_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // disagreeing bits keep their old value
    always_ff @(posedge clk) begin
        if (srst) begin
            q_reg <= '0;
        end else begin
            q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
        end
    end

    assign q = q_reg;
endmodule : tppm_sync

// File: design/tppm_ahb_slave.sv
// ahb-lite slave front end: zero-wait writes, one wait state on reads
// assumes a single master; hready is this slave's own hreadyout
`timescale 1ns/10ps
module tppm_ahb_slave
    import tppm_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // ahb-lite
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // register side
    output logic                       wr_en,
    output logic [REG_ADDR_W-1:0]      wr_addr,
    output logic [REG_ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]           rd_data
);
    logic                  accept;
    logic                  mapped;
    logic                  wr_pend_reg;
    logic                  rd_pend_reg;
    logic                  ready_reg;
    logic [REG_ADDR_W-1:0] wr_addr_reg;
    logic [REG_ADDR_W-1:0] rd_addr_reg;
    logic [31:0]           hrdata_reg;

    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign mapped = (haddr[31:REG_ADDR_W] == '0) && (hsize == HSIZE_WORD);

    // write commits in its data phase, when hwdata stands
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= accept && hwrite && mapped;
            wr_addr_reg <= haddr[REG_ADDR_W-1:0];
        end
    end

    // read sampled one cycle late so a preceding write is already visible
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= ADDR_UNMAPPED;
            ready_reg   <= 1'b1;
            hrdata_reg  <= '0;
        end else begin
            rd_pend_reg <= accept && !hwrite;
            ready_reg   <= !(accept && !hwrite);
            if (accept && !hwrite) begin
                rd_addr_reg <= mapped ? haddr[REG_ADDR_W-1:0] : ADDR_UNMAPPED;
            end
            if (rd_pend_reg) begin
                hrdata_reg <= rd_data;
            end
        end
    end

    assign wr_en     = wr_pend_reg;
    assign wr_addr   = wr_addr_reg;
    assign rd_addr   = rd_addr_reg;
    assign hreadyout = ready_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
endmodule : tppm_ahb_slave

// File: design/tppm_port_mux.sv
// three-pin port with direction, pull-up, data latch and priority mux
// assumes peripherals share clk; pads are outside the clock domain
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module tppm_port_mux
    import tppm_pkg::*;
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      srst,
    // ahb-lite
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    // peripherals
    input  wire tppm_pkg::tppm_periph_in_type   periph_in,
    output tppm_pkg::tppm_periph_out_type       periph_out,
    // pads
    input  wire logic [tppm_pkg::NUM_PINS-1:0]  pad_in,
    output tppm_pkg::tppm_pad_out_type          pad_o
);
    import tppm_pkg::*;

    // =========================================================
    // declarations
    logic                  wr_en;
    logic [REG_ADDR_W-1:0] wr_addr;
    logic [REG_ADDR_W-1:0] rd_addr;
    logic [31:0]           rd_data;
    logic [7:0]            cfg_one_reg;
    logic [7:0]            cfg_two_reg;
    logic [7:0]            data_reg;
    logic [NUM_PINS-1:0]   pin_sync;
    logic [NUM_PINS-1:0]   dir;
    logic [NUM_PINS-1:0]   pue;
    logic [NUM_PINS-1:0]   latch;
    logic                  pwm_cs;
    logic                  pwm_en;
    tppm_sermode_type      ser_mode;
    logic [NUM_PINS-1:0]   pin_free;
    logic [NUM_PINS-1:0]   alt_act;
    logic [NUM_PINS-1:0]   alt_oe;
    logic [NUM_PINS-1:0]   alt_out;
    logic [NUM_PINS-1:0]   out_next;
    logic [NUM_PINS-1:0]   oe_next;
    logic [NUM_PINS-1:0]   pu_next;
    logic                  sci_rxd_next;
    logic                  lin_txd_next;
    tppm_pad_out_type      pad_reg;
    tppm_periph_out_type   periph_reg;

    // =========================================================
    // address decode
    function automatic logic hit(input logic [REG_ADDR_W-1:0] a, input logic [REG_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // =========================================================
    // bus front end
    tppm_ahb_slave u_bus (
        .clk       (clk),
        .srst      (srst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data)
    );

    // =========================================================
    // pin synchronisers
    // sync pad inputs
    tppm_sync #(
        .WIDTH (NUM_PINS)
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        .d    (pad_in),
        .q    (pin_sync)
    );

    // =========================================================
    // registers
    // clear on reset
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_one_reg <= CFG_ONE_RESET;
        end else if (wr_en && hit(wr_addr, ADDR_CFG_ONE)) begin
            cfg_one_reg <= hwdata[7:0] & CFG_ONE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_two_reg <= CFG_TWO_RESET;
        end else if (wr_en && hit(wr_addr, ADDR_CFG_TWO)) begin
            cfg_two_reg <= hwdata[7:0] & CFG_TWO_MASK;
        end
    end

    // latch is written for input pins too and shows once they turn output
    always_ff @(posedge clk) begin
        if (srst) begin
            data_reg <= DATA_RESET;
        end else if (wr_en && hit(wr_addr, ADDR_DATA)) begin
            data_reg <= hwdata[7:0] & DATA_MASK;
        end
    end

    assign pue      = cfg_one_reg[PUE_LSB +: NUM_PINS];
    assign dir      = cfg_one_reg[DIR_LSB +: NUM_PINS];
    assign latch    = data_reg[DATA_LSB +: NUM_PINS];
    assign pwm_cs   = cfg_two_reg[PWM_CHANNEL_SELECT_BIT];
    assign pwm_en   = cfg_two_reg[PWM_ROUTE_ENABLE_BIT];
    assign ser_mode = tppm_sermode_type'(cfg_two_reg[SERIAL_MODE_LSB +: 2]);

    // latch for outputs, pin for inputs
    always_comb begin
        rd_data = '0;
        if (hit(rd_addr, ADDR_CFG_ONE)) begin
            rd_data[7:0] = cfg_one_reg;
        end else if (hit(rd_addr, ADDR_CFG_TWO)) begin
            rd_data[7:0] = cfg_two_reg;
        end else if (hit(rd_addr, ADDR_DATA)) begin
            rd_data[DATA_LSB +: NUM_PINS] = (latch & dir) | (pin_sync & ~dir);
        end
    end

    // =========================================================
    // third priority level: serial and pwm
    // claims come from ser_mode and pwm_en; pin_free comes from the analog and timer peripheral enables
    assign pin_free = ~periph_in.analog_en & ~periph_in.timer_en;

    always_comb begin
        alt_act = '0;
        alt_oe  = '0;
        alt_out = '0;
        case (ser_mode)
            SER_INTERNAL: begin
                alt_act[1:0] = 2'h0;
            end
            // pin 0 rx in, pin 1 tx out
            SER_EXT_SCI: begin
                alt_act[1:0] = 2'h3;
                alt_oe[1:0]  = 2'h2;
                alt_out[1]   = periph_in.sci_txd;
            end
            // phy rx out, phy tx in
            SER_EXT_LIN: begin
                alt_act[1:0] = 2'h3;
                alt_oe[1:0]  = 2'h1;
                alt_out[0]   = periph_in.lin_rxd;
            end
            SER_OBSERVE: begin
                alt_act[1:0] = 2'h3;
                alt_oe[1:0]  = 2'h3;
                alt_out[0]   = periph_in.lin_rxd;
                alt_out[1]   = periph_in.sci_txd;
            end
            default: begin
                alt_act[1:0] = 2'h0;
            end
        endcase
        alt_act[2] = pwm_en;
        alt_oe[2]  = pwm_en;
        alt_out[2] = pwm_en && periph_in.pwm_out[pwm_cs];
    end

    // =========================================================
    // per-pin priority mux
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            always_comb begin
                if (periph_in.analog_en[gi]) begin
                    out_next[gi] = 1'b0;
                    oe_next[gi]  = 1'b0;
                end else if (periph_in.timer_en[gi]) begin
                    out_next[gi] = periph_in.timer_oc[gi] && periph_in.timer_out[gi];
                    oe_next[gi]  = periph_in.timer_oc[gi];
                end else if (alt_act[gi]) begin
                    out_next[gi] = alt_out[gi];
                    oe_next[gi]  = alt_oe[gi];
                end else begin
                    out_next[gi] = latch[gi];
                    oe_next[gi]  = dir[gi];
                end
            end
            // no pull-up while driven; analog pins float
            assign pu_next[gi] = pue[gi] && !oe_next[gi] && !periph_in.analog_en[gi]
                               && (alt_act[gi] || periph_in.timer_en[gi] || !dir[gi]);
        end
    endgenerate

    // =========================================================
    // internal serial routing
    always_comb begin
        sci_rxd_next = IDLE_LINE;
        lin_txd_next = IDLE_LINE;
        case (ser_mode)
            SER_INTERNAL: begin
                sci_rxd_next = periph_in.lin_rxd;
                lin_txd_next = periph_in.sci_txd;
            end
            // sci rx from pin 0; a pin lost to priority reads idle
            SER_EXT_SCI: begin
                sci_rxd_next = pin_free[0] ? pin_sync[0] : IDLE_LINE;
            end
            SER_EXT_LIN: begin
                lin_txd_next = pin_free[1] ? pin_sync[1] : IDLE_LINE;
            end
            SER_OBSERVE: begin
                sci_rxd_next = periph_in.lin_rxd;
                lin_txd_next = periph_in.sci_txd;
            end
            default: begin
                sci_rxd_next = IDLE_LINE;
            end
        endcase
    end

    // =========================================================
    // output flops
    always_ff @(posedge clk) begin
        if (srst) begin
            pad_reg <= '0;
        end else begin
            pad_reg.out <= out_next;
            pad_reg.oe  <= oe_next;
            pad_reg.pu  <= pu_next;
        end
    end

    // timer channel 3 compare output is simply not connected
    always_ff @(posedge clk) begin
        if (srst) begin
            periph_reg <= '{timer_in: '0, sci_rxd: IDLE_LINE, lin_txd: IDLE_LINE};
        end else begin
            periph_reg.timer_in[NUM_PINS-1:0] <= pin_sync;
            periph_reg.timer_in[3] <= sci_rxd_next;
            periph_reg.sci_rxd     <= sci_rxd_next;
            periph_reg.lin_txd     <= lin_txd_next;
        end
    end

    assign pad_o      = pad_reg;
    assign periph_out = periph_reg;

    // =========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_ANALOG_WINS: assert property (
        ##1 ((pad_o.oe | pad_o.pu) & $past(periph_in.analog_en)) == '0)
        else $error("analog pin driven or pulled");

    AST_TIMER_OC: assert property (
        (periph_in.timer_en[2] && periph_in.timer_oc[2] && !periph_in.analog_en[2])
        |=> pad_o.oe[2] && (pad_o.out[2] == $past(periph_in.timer_out[2])))
        else $error("timer compare not on pin 2");

    AST_TIMER_OVER_PWM: assert property (
        (pwm_en && periph_in.timer_en[2] && !periph_in.analog_en[2])
        |=> pad_o.oe[2] == $past(periph_in.timer_oc[2])
            && pad_o.out[2] == $past(periph_in.timer_oc[2] && periph_in.timer_out[2]))
        else $error("pwm not overridden by timer");

    AST_PU_OFF_OUT: assert property (
        (pad_o.pu & pad_o.oe) == '0)
        else $error("pull-up on driven pin");

    AST_GPIO_DIR: assert property (
        (pin_free[2] && !pwm_en) |=> pad_o.oe[2] == $past(dir[2]) && pad_o.out[2] == $past(latch[2]))
        else $error("pin 2 gpio direction wrong");

    AST_GPIO_PU: assert property (
        (pin_free[0] && ser_mode == SER_INTERNAL) |=> pad_o.pu[0] == $past(pue[0] && !dir[0]))
        else $error("pin 0 pull-up wrong");

    AST_PWM_ROUTE: assert property (
        (pin_free[2] && pwm_en) |=> pad_o.oe[2] && pad_o.out[2] == $past(periph_in.pwm_out[pwm_cs]))
        else $error("pwm not on pin 2");

    AST_SER_INTERNAL: assert property (
        (ser_mode == SER_INTERNAL) |=> periph_out.sci_rxd == $past(periph_in.lin_rxd)
                                     && periph_out.lin_txd == $past(periph_in.sci_txd))
        else $error("internal serial link broken");

    AST_EXT_SCI: assert property (
        (ser_mode == SER_EXT_SCI && pin_free[1]) |=> pad_o.oe[1] && pad_o.out[1] == $past(periph_in.sci_txd))
        else $error("sci tx not on pin 1");

    AST_EXT_LIN: assert property (
        (ser_mode == SER_EXT_LIN && pin_free[0]) |=> pad_o.oe[0] && pad_o.out[0] == $past(periph_in.lin_rxd))
        else $error("phy rx not on pin 0");

    AST_OBSERVE: assert property (
        (ser_mode == SER_OBSERVE && pin_free[0] && pin_free[1]) |=> pad_o.oe[1:0] == 2'h3)
        else $error("observe pins not driven");

    AST_CH3_RX: assert property (
        (ser_mode == SER_INTERNAL) |=> periph_out.timer_in[3] == $past(periph_in.lin_rxd))
        else $error("channel 3 not on rx");

    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        srst |=> cfg_one_reg == CFG_ONE_RESET && cfg_two_reg == CFG_TWO_RESET && pad_o.oe == '0)
        else $error("configuration not cleared");

    CVR_EXT_SCI: cover property (ser_mode == SER_EXT_SCI ##1 pad_o.oe[1]);
    CVR_PWM:     cover property (pwm_en && pwm_cs ##1 pad_o.oe[2]);
    CVR_ANALOG:  cover property (periph_in.analog_en[0] && dir[0]);
    CVR_OBSERVE: cover property (ser_mode == SER_OBSERVE ##1 pad_o.oe[1:0] == 2'h3);
endmodule : tppm_port_mux

// File: tb/tppm_pad_model.sv
// far-side model: pad wires between the port and the outside world
// assumes pad_o is registered in the same clk domain as the bench
`timescale 1ns/10ps
module tppm_pad_model
    import tppm_pkg::*;
(
    // clock
    input  wire logic                       clk,
    // port side
    input  wire tppm_pkg::tppm_pad_out_type pad_o,
    output logic [2:0]                      pad_in,
    // external drivers
    input  wire logic [2:0]                 ext_en,
    input  wire logic [2:0]                 ext_val
);
    // =========================================================
    // wire resolution
    logic [2:0] last_reg = 3'h0;

    always @(posedge clk) begin
        last_reg <= pad_in;
    end

    // floating pin toggles so no stale level reads as valid
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pad_in[i] = pad_o.oe[i] ? pad_o.out[i] : ext_en[i] ? ext_val[i] : pad_o.pu[i] ? 1'b1 : ~last_reg[i];
        end
    end
endmodule : tppm_pad_model

// File: tb/tb.sv
// self-checking bench for the three-pin port multiplexer
// assumes one-slave ahb-lite with hready tied to hreadyout
`timescale 1ns/10ps
module tb;
    import tppm_pkg::*;
    // =========================================================
    // signals
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    logic                hsel = 1'b0;
    logic [31:0]         haddr = 32'h0;
    logic [1:0]          htrans = 2'h0;
    logic                hwrite = 1'b0;
    logic [2:0]          hsize = HSIZE_WORD;
    logic [31:0]         hwdata = 32'h0;
    logic                hreadyout;
    logic                hresp;
    logic [31:0]         hrdata;
    tppm_periph_in_type  pin = '0;
    tppm_periph_out_type pout;
    tppm_pad_out_type    pad_o;
    logic [2:0]          pad_in;
    logic [2:0]          ext_en = 3'h0;
    logic [2:0]          ext_val = 3'h0;
    int                  error_cnt = 0;
    int                  checked = 0;
    int                  cyc = 0;
    logic [31:0]         r;
    logic [6:0]          tbl [4] = '{7'b0000010, 7'b1010010, 7'b0100101, 7'b1110010};

    always #2 clk = ~clk;

    tppm_port_mux DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .periph_in(pin), .periph_out(pout), .pad_in(pad_in), .pad_o(pad_o));
    tppm_pad_model PADS (.clk(clk), .pad_o(pad_o), .pad_in(pad_in), .ext_en(ext_en), .ext_val(ext_val));

    // =========================================================
    // tasks
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // hold address phase until hready, then data phase until hready
    task automatic ahb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {28'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask : ahb

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        ahb(1'b0, a, 8'h00);
        chk(r, {24'h0, exp});
        chk({31'h0, hresp}, 32'h0);
    endtask : rd

    task automatic settle;
        repeat (8) @(posedge clk);
    endtask : settle

    // =========================================================
    // timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // =========================================================
    // tests
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(ADDR_CFG_ONE, 8'h00);
        rd(ADDR_CFG_TWO, 8'h00);
        chk(pad_o, '0);
        ahb(1'b1, ADDR_UNMAPPED, 8'hFF);
        rd(ADDR_UNMAPPED, 8'h00);
        $display("test reset done");
        ahb(1'b1, ADDR_CFG_ONE, 8'hFF);
        rd(ADDR_CFG_ONE, 8'h77);
        settle();
        chk({pad_o.oe, pad_o.pu}, 6'b111000);
        ahb(1'b1, ADDR_CFG_ONE, 8'h70);
        settle();
        chk({pad_o.oe, pad_o.pu}, 6'b000111);
        $display("test pullup done");
        ahb(1'b1, ADDR_CFG_ONE, 8'h00);
        ext_en <= 3'b011;
        pin.sci_txd <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            ahb(1'b1, ADDR_CFG_TWO, 8'(m));
            settle();
            chk({pad_o.oe[1:0], pad_o.out[1:0] & pad_o.oe[1:0], pout.sci_rxd, pout.lin_txd, pout.timer_in[3]}, tbl[m]);
        end
        $display("test serial done");
        ahb(1'b1, ADDR_CFG_TWO, 8'h00);
        ahb(1'b1, ADDR_CFG_ONE, 8'h05);
        ahb(1'b1, ADDR_DATA, 8'h07);
        ext_en <= 3'b010;
        ext_val <= 3'b000;
        settle();
        rd(ADDR_DATA, 8'h05);
        chk(pout.timer_in[2:0], 3'b101);
        ext_val <= 3'b010;
        settle();
        rd(ADDR_DATA, 8'h07);
        chk(pout.timer_in[2:0], 3'b111);
        $display("test data done");
        ahb(1'b1, ADDR_CFG_ONE, 8'h00);
        pin.pwm_out <= 2'b01;
        ahb(1'b1, ADDR_CFG_TWO, 8'h04);
        settle();
        chk({pad_o.oe[2], pad_o.out[2]}, 2'b11);
        ahb(1'b1, ADDR_CFG_TWO, 8'h0C);
        settle();
        chk({pad_o.oe[2], pad_o.out[2]}, 2'b10);
        ahb(1'b1, ADDR_CFG_TWO, 8'h04);
        pin.timer_en[2] <= 1'b1;
        pin.timer_oc[2] <= 1'b1;
        settle();
        chk({pad_o.oe[2], pad_o.out[2]}, 2'b10);
        ahb(1'b1, ADDR_CFG_ONE, 8'h40);
        pin.analog_en[2] <= 1'b1;
        settle();
        chk({pad_o.oe[2], pad_o.pu[2]}, 2'b00);
        $display("test priority done");
        print_verdict();
    end
endmodule : tb
